// ### include/bps_pkg.sv
package bps_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned CNT_W = 32;
	localparam int unsigned N_IN = 20;
	// Filter and persistence times; least times round up.
	localparam int unsigned T_INV_FILT_NS = 500;
	localparam int unsigned INV_FILT_CYC = (T_INV_FILT_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned T_BOOST_FILT_NS = 200;
	localparam int unsigned BOOST_FILT_CYC = (T_BOOST_FILT_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned T_CAP2_US = 620;
	localparam int unsigned CAP2_CYC = T_CAP2_US * CLK_MHZ;
	localparam int unsigned T_CAP1_MS = 2500;
	localparam int unsigned CAP1_CYC = T_CAP1_MS * CLK_MHZ * 1000;
	localparam int unsigned T_BUSOV_MS = 625;
	localparam int unsigned BUSOV_CYC = T_BUSOV_MS * CLK_MHZ * 1000;
	localparam int unsigned T_RETRY_MS = 100;
	localparam int unsigned RETRY_CYC = T_RETRY_MS * CLK_MHZ * 1000;
	localparam int unsigned T_PREHEAT_MS = 1000;
	localparam int unsigned PREHEAT_CYC = T_PREHEAT_MS * CLK_MHZ * 1000;
	localparam logic [2:0] RETRY_MAX = 3'h7;
	// Boost timing.
	localparam int unsigned T_RESTART_US = 52;
	localparam int unsigned RESTART_CYC = T_RESTART_US * CLK_MHZ;
	localparam int unsigned T_BOOST_TOFF_US = 47;
	localparam int unsigned BOOST_TOFF_CYC = T_BOOST_TOFF_US * CLK_MHZ;
	localparam int unsigned T_BOOST_TON0_NS = 4000;
	localparam int unsigned BOOST_TON0_CYC = T_BOOST_TON0_NS * CLK_MHZ / 1000;
	localparam int unsigned T_BOOST_TONMAX_NS = 22700;
	localparam int unsigned BOOST_TONMAX_CYC = T_BOOST_TONMAX_NS * CLK_MHZ / 1000;
	localparam int unsigned TON_STEP_CYC = 25;
	localparam logic [3:0] ZCD_LOCK_CNT = 4'h8;
	localparam int unsigned T_OV_STOP_NS = 5000;
	localparam int unsigned OV_STOP_CYC = T_OV_STOP_NS * CLK_MHZ / 1000;
	// Half-bridge dead time bounds; least rounds up, longest rounds down.
	localparam int unsigned DT_W = 10;
	localparam int unsigned T_DT_MIN_NS = 1250;
	localparam logic [DT_W-1:0] DT_MIN_CYC = DT_W'((T_DT_MIN_NS * CLK_MHZ + 999) / 1000);
	localparam int unsigned T_DT_MAX_NS = 2500;
	localparam logic [DT_W-1:0] DT_MAX_CYC = DT_W'(T_DT_MAX_NS * CLK_MHZ / 1000);
	typedef enum logic [2:0] {
		SEQ_LOCK, SEQ_START, SEQ_PREHEAT, SEQ_IGNITE, SEQ_RUN, SEQ_PDOWN, SEQ_FAULT
	} bps_seq_t;
	typedef enum logic [1:0] {BST_IDLE, BST_ON, BST_OFF} bps_bst_t;
endpackage : bps_pkg

// ### rtl/bps_persist.sv
// Persistence filter: the expired level rises once the flag has stayed high for more
// than LIMIT cycles and drops as soon as the flag drops.
module bps_persist #(
	parameter int unsigned LIMIT = 1
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic flag_in,
	output logic expired_out
);
	import bps_pkg::*;

	logic [CNT_W-1:0] cnt_q;

	// Counter saturates at the limit so very long limits never wrap.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_q <= '0;
			expired_out <= 1'b0;
		end else if (!flag_in) begin
			cnt_q <= '0;
			expired_out <= 1'b0;
		end else begin
			if (cnt_q < LIMIT) begin
				cnt_q <= cnt_q + 32'h1;
			end
			expired_out <= (cnt_q >= LIMIT);
		end
	end
endmodule : bps_persist

// ### rtl/bps_deadtime.sv
// Half-bridge gate pair with adaptive dead time.
module bps_deadtime (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic en_in,
	input wire logic flip_in,
	input wire logic neg_in,
	output logic ls_out,
	output logic hs_out,
	output logic hs_on_out
);
	import bps_pkg::*;

	logic tgt_q;
	logic busy_q;
	logic [DT_W-1:0] cnt_q;

	// Each flip drops both gates; the other gate rises after the minimum gap once the
	// negative-current comparator shows the switch node has swung, or at the maximum.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ls_out <= 1'b0;
			hs_out <= 1'b0;
			hs_on_out <= 1'b0;
			busy_q <= 1'b0;
			cnt_q <= '0;
			tgt_q <= 1'b1;
		end else if (!en_in) begin
			ls_out <= 1'b0;
			hs_out <= 1'b0;
			hs_on_out <= 1'b0;
			busy_q <= 1'b0;
			cnt_q <= '0;
			tgt_q <= 1'b1; // Low side first so the bootstrap charges.
		end else begin
			hs_on_out <= 1'b0;
			if (flip_in) begin
				ls_out <= 1'b0;
				hs_out <= 1'b0;
				busy_q <= 1'b1;
				cnt_q <= '0;
				tgt_q <= ~tgt_q;
			end else if (busy_q) begin
				if (cnt_q >= DT_MIN_CYC && (neg_in || cnt_q >= DT_MAX_CYC)) begin
					busy_q <= 1'b0;
					ls_out <= ~tgt_q;
					hs_out <= tgt_q;
					hs_on_out <= tgt_q;
				end else begin
					cnt_q <= cnt_q + 10'h1;
				end
			end
		end
	end
endmodule : bps_deadtime

// ### rtl/bps_top.sv
// Ballast supervision: lockout, start sequence, inverter protection and boost control.
module bps_top #(
	parameter int unsigned CAP2_LIM = bps_pkg::CAP2_CYC,
	parameter int unsigned CAP1_LIM = bps_pkg::CAP1_CYC,
	parameter int unsigned BUSOV_LIM = bps_pkg::BUSOV_CYC,
	parameter int unsigned RETRY_LIM = bps_pkg::RETRY_CYC,
	parameter int unsigned PREHEAT_LIM = bps_pkg::PREHEAT_CYC,
	parameter int unsigned RESTART_LIM = bps_pkg::RESTART_CYC,
	parameter int unsigned BOOST_TOFF = bps_pkg::BOOST_TOFF_CYC,
	parameter int unsigned BOOST_TONMAX = bps_pkg::BOOST_TONMAX_CYC
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic inv_oc1_in,
	input wire logic inv_slope_in,
	input wire logic inv_oc2_in,
	input wire logic inv_pos_in,
	input wire logic inv_neg_in,
	input wire logic inv_oc3_in,
	input wire logic boost_oc_in,
	input wire logic zcd_high_in,
	input wire logic zcd_low_in,
	input wire logic vcc_on_in,
	input wire logic vcc_uv_in,
	input wire logic bus_open_in,
	input wire logic bus_uv_in,
	input wire logic bus_ov_in,
	input wire logic bus_rel_in,
	input wire logic bus_ok_in,
	input wire logic line_low_in,
	input wire logic light_load_in,
	input wire logic inv_osc_in,
	input wire logic lamp_lit_in,
	output logic low_side_gate_out,
	output logic high_side_gate_out,
	output logic boost_gate_out,
	output logic freq_hold_out,
	output logic fault_out,
	output logic inv_ov_out,
	output logic dcm_out,
	output logic run_out
);
	import bps_pkg::*;

	logic [N_IN-1:0] raw;
	logic [N_IN-1:0] meta_q;
	logic [N_IN-1:0] sync_q;
	logic oc1_s, slope_s, oc2_s, pos_s, neg_s, oc3_s, boc_s, zhi_s, zlo_s, von_s;
	logic vuv_s, open_s, buv_s, bov_s, rel_s, bok_s, llow_s, lload_s, osc_s, lit_s;
	logic oc1_x, oc2_x, boc_x, cap1_x, cap2_x, busov_x;
	bps_seq_t seq_q;
	bps_bst_t bst_q;
	logic [CNT_W-1:0] seq_cnt_q;
	logic [2:0] retry_q;
	logic skip_q;
	logic inv_ov_q;
	logic inv_en;
	logic boost_act;
	logic boost_run;
	logic start_ok;
	logic run_mode;
	logic osc_d_q;
	logic flip;
	logic dt_ls, dt_hs, dt_hs_on;
	logic ls_d_q;
	logic [15:0] ls_cnt_q;
	logic [15:0] ls_len_q;
	logic pos_seen_q;
	logic cap1_q;
	logic cap2_q;
	logic ov_stop_q;
	logic zstate_q;
	logic zfall;
	logic [CNT_W-1:0] bcnt_q;
	logic [CNT_W-1:0] ton_q;
	logic [CNT_W-1:0] ton_eff;
	logic [3:0] zcnt_q;
	logic var_q;
	logic gap_q;
	logic oc_hold_q;
	logic boost_start;

	// Every pin flag crosses into the clock domain through two flip-flops.
	assign raw = {inv_oc1_in, inv_slope_in, inv_oc2_in, inv_pos_in, inv_neg_in, inv_oc3_in,
		boost_oc_in, zcd_high_in, zcd_low_in, vcc_on_in, vcc_uv_in, bus_open_in, bus_uv_in,
		bus_ov_in, bus_rel_in, bus_ok_in, line_low_in, light_load_in, inv_osc_in, lamp_lit_in};
	assign {oc1_s, slope_s, oc2_s, pos_s, neg_s, oc3_s, boc_s, zhi_s, zlo_s, von_s,
		vuv_s, open_s, buv_s, bov_s, rel_s, bok_s, llow_s, lload_s, osc_s, lit_s} = sync_q;

	for (genvar i = 0; i < N_IN; i++) begin : g_sync
		always_ff @(posedge clk_in or negedge arst_n_in) begin
			if (!arst_n_in) begin
				meta_q[i] <= 1'b0;
				sync_q[i] <= 1'b0;
			end else begin
				meta_q[i] <= raw[i];
				sync_q[i] <= meta_q[i];
			end
		end
	end

	// Persistence filters for the fault flags.
	bps_persist #(.LIMIT(INV_FILT_CYC)) u_oc1 (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.flag_in(oc1_s), .expired_out(oc1_x));
	bps_persist #(.LIMIT(INV_FILT_CYC)) u_oc2 (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.flag_in(oc2_s), .expired_out(oc2_x));
	bps_persist #(.LIMIT(BOOST_FILT_CYC)) u_boc (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.flag_in(boc_s), .expired_out(boc_x));
	bps_persist #(.LIMIT(CAP1_LIM)) u_cap1 (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.flag_in(cap1_q && run_mode), .expired_out(cap1_x));
	bps_persist #(.LIMIT(CAP2_LIM)) u_cap2 (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.flag_in(cap2_q && run_mode), .expired_out(cap2_x));
	bps_persist #(.LIMIT(BUSOV_LIM)) u_busov (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.flag_in(bov_s && inv_en), .expired_out(busov_x));

	// Mode decodes used by both the inverter and the boost paths.
	assign run_mode = (seq_q == SEQ_RUN);
	assign inv_en = (seq_q == SEQ_PREHEAT) || (seq_q == SEQ_IGNITE) || run_mode;
	assign boost_act = (seq_q == SEQ_START) || inv_en;
	// The boost is cut at once on overvoltage, and on an open loop in run mode.
	assign boost_run = boost_act && !ov_stop_q && !bov_s && !(open_s && run_mode);
	// A restart needs the bus below the overvoltage level and still above undervoltage.
	assign start_ok = !bov_s && !buv_s;

	// Start sequence, lockout and power-down retries.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			seq_q <= SEQ_LOCK;
			seq_cnt_q <= '0;
			retry_q <= '0;
			skip_q <= 1'b0;
			inv_ov_q <= 1'b0;
		end else if (vuv_s) begin
			seq_q <= SEQ_LOCK;
			seq_cnt_q <= '0;
			retry_q <= '0;
			skip_q <= 1'b0;
			inv_ov_q <= 1'b0;
		end else begin
			unique case (seq_q)
				SEQ_LOCK: begin
					if (von_s) begin
						seq_q <= SEQ_START;
					end
				end
				SEQ_START: begin
					if (oc2_x) begin
						seq_q <= SEQ_FAULT;
					end else if (bok_s) begin
						seq_q <= skip_q ? SEQ_IGNITE : SEQ_PREHEAT;
						seq_cnt_q <= '0;
					end
				end
				SEQ_PREHEAT: begin
					if (oc1_x || oc2_x) begin
						seq_q <= SEQ_FAULT;
					end else if (busov_x) begin
						seq_q <= SEQ_PDOWN;
						inv_ov_q <= 1'b1;
						seq_cnt_q <= '0;
					end else if (seq_cnt_q >= PREHEAT_LIM) begin
						seq_q <= SEQ_IGNITE;
					end else begin
						seq_cnt_q <= seq_cnt_q + 32'h1;
					end
				end
				SEQ_IGNITE: begin
					if (oc2_x) begin
						seq_q <= SEQ_FAULT;
					end else if (lit_s) begin
						seq_q <= SEQ_RUN;
						retry_q <= '0;
						skip_q <= 1'b0;
					end
				end
				SEQ_RUN: begin
					if (oc1_x || cap1_x || cap2_x) begin
						seq_q <= SEQ_FAULT;
					end else if (busov_x) begin
						seq_q <= SEQ_PDOWN;
						inv_ov_q <= 1'b1;
						seq_cnt_q <= '0;
					end else if (buv_s) begin
						seq_q <= SEQ_PDOWN;
						seq_cnt_q <= '0;
					end
				end
				SEQ_PDOWN: begin
					if (seq_cnt_q >= RETRY_LIM) begin
						seq_cnt_q <= '0;
						if (retry_q < RETRY_MAX) begin
							retry_q <= retry_q + 3'h1;
						end
						if (start_ok) begin
							seq_q <= SEQ_START;
							skip_q <= (retry_q < RETRY_MAX);
							inv_ov_q <= 1'b0;
						end
					end else begin
						seq_cnt_q <= seq_cnt_q + 32'h1;
					end
				end
				SEQ_FAULT: begin
					seq_q <= SEQ_FAULT; // Only lockout leaves a latched fault.
				end
			endcase
		end
	end

	// Ignition hold: once slope and first level coincide the sweep freezes until run.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			freq_hold_out <= 1'b0;
		end else begin
			freq_hold_out <= (seq_q == SEQ_IGNITE) && (freq_hold_out || (slope_s && oc1_s));
		end
	end

	// Oscillator edges from the inverter timing pin request a half-bridge flip.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			osc_d_q <= 1'b0;
		end else begin
			osc_d_q <= osc_s;
		end
	end
	assign flip = (osc_s ^ osc_d_q) && inv_en;

	bps_deadtime u_dt (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.en_in(inv_en),
		.flip_in(flip),
		.neg_in(neg_s),
		.ls_out(dt_ls),
		.hs_out(dt_hs),
		.hs_on_out(dt_hs_on)
	);

	// Low-side on-time watch: positive current must show in the second half.
	// The half point uses the previous period's length, so the first period is lenient.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ls_d_q <= 1'b0;
			ls_cnt_q <= '0;
			ls_len_q <= '0;
			pos_seen_q <= 1'b0;
			cap1_q <= 1'b0;
		end else begin
			ls_d_q <= dt_ls;
			if (dt_ls) begin
				ls_cnt_q <= ls_cnt_q + 16'h1;
				if (pos_s && ls_cnt_q >= (ls_len_q >> 1)) begin
					pos_seen_q <= 1'b1;
				end
			end else if (ls_d_q) begin
				ls_len_q <= ls_cnt_q;
				ls_cnt_q <= '0;
				pos_seen_q <= 1'b0;
				cap1_q <= !pos_seen_q;
			end
			if (!run_mode) begin
				cap1_q <= 1'b0;
			end
		end
	end

	// Hard switching at high-side turn-on: negative current when the low side is released,
	// or a reverse recovery spike while the high side conducts. Held until the next high-side turn-on.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cap2_q <= 1'b0;
		end else if (!run_mode) begin
			cap2_q <= 1'b0;
		end else if ((flip && dt_ls && neg_s) || (dt_hs && oc3_s)) begin
			cap2_q <= 1'b1;
		end else if (dt_hs_on) begin
			cap2_q <= 1'b0;
		end
	end

	// Overvoltage stop holds until the bus falls under the release level.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ov_stop_q <= 1'b0;
		end else if (bov_s) begin
			ov_stop_q <= 1'b1;
		end else if (!rel_s) begin
			ov_stop_q <= 1'b0;
		end
	end

	// Hysteretic zero-current state: set above the upper level, cleared below the lower.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			zstate_q <= 1'b0;
		end else if (zhi_s) begin
			zstate_q <= 1'b1;
		end else if (zlo_s) begin
			zstate_q <= 1'b0;
		end
	end
	assign zfall = zstate_q && zlo_s && !zhi_s;

	// Low line stretches the on-time by a quarter to fill the zero-crossing gap.
	assign ton_eff = llow_s ? ton_q + (ton_q >> 2) : ton_q;
	// Light load skips the first zero-current ring, leaving a gap before the next pulse.
	assign boost_start = (var_q && zfall && !(lload_s && !gap_q))
		|| (oc_hold_q && zfall)
		|| (bcnt_q >= RESTART_LIM)
		|| (!var_q && !oc_hold_q && bcnt_q >= BOOST_TOFF);

	// Boost pulse generator.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			bst_q <= BST_IDLE;
			bcnt_q <= '0;
			ton_q <= BOOST_TON0_CYC;
			zcnt_q <= '0;
			var_q <= 1'b0;
			gap_q <= 1'b0;
			oc_hold_q <= 1'b0;
		end else if (!boost_run) begin
			bst_q <= BST_IDLE;
			bcnt_q <= '0;
			if (!boost_act) begin
				ton_q <= BOOST_TON0_CYC;
				zcnt_q <= '0;
				var_q <= 1'b0;
			end
		end else begin
			unique case (bst_q)
				BST_IDLE: begin
					bst_q <= BST_ON;
					bcnt_q <= '0;
				end
				BST_ON: begin
					if (boc_x || bcnt_q >= ton_eff) begin
						bst_q <= BST_OFF;
						bcnt_q <= '0;
						gap_q <= 1'b0;
						oc_hold_q <= boc_x;
					end else begin
						bcnt_q <= bcnt_q + 32'h1;
					end
				end
				BST_OFF: begin
					if (zfall && zcnt_q < ZCD_LOCK_CNT) begin
						zcnt_q <= zcnt_q + 4'h1;
					end
					if (zcnt_q >= ZCD_LOCK_CNT) begin
						var_q <= 1'b1;
					end
					if (boost_start) begin
						bst_q <= BST_ON;
						bcnt_q <= '0;
						oc_hold_q <= 1'b0;
						if (!var_q && ton_q < BOOST_TONMAX) begin
							ton_q <= ton_q + TON_STEP_CYC;
						end
					end else begin
						bcnt_q <= bcnt_q + 32'h1;
						if (var_q && zfall && lload_s) begin
							gap_q <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	// Output flops; gates are forced low in lockout and outside active modes.
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			low_side_gate_out <= 1'b0;
			high_side_gate_out <= 1'b0;
			boost_gate_out <= 1'b0;
			fault_out <= 1'b0;
			inv_ov_out <= 1'b0;
			dcm_out <= 1'b0;
			run_out <= 1'b0;
		end else begin
			low_side_gate_out <= dt_ls && inv_en;
			high_side_gate_out <= dt_hs && inv_en;
			boost_gate_out <= (bst_q == BST_ON) && boost_run;
			fault_out <= (seq_q == SEQ_FAULT);
			inv_ov_out <= inv_ov_q;
			dcm_out <= var_q && lload_s && boost_act;
			run_out <= run_mode;
		end
	end

	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);

	lockout_gates_low_a: assert property (
		seq_q == SEQ_LOCK |=> !low_side_gate_out && !high_side_gate_out && !boost_gate_out)
		else $error("Gate driven during lockout.");
	lockout_hold_a: assert property (
		seq_q == SEQ_LOCK && !von_s |=> seq_q == SEQ_LOCK)
		else $error("Lockout left without turn-on flag.");
	oc1_latch_a: assert property (
		oc1_x && !vuv_s && (seq_q == SEQ_PREHEAT || seq_q == SEQ_RUN) |=> seq_q == SEQ_FAULT)
		else $error("First-level overcurrent did not latch shutdown.");
	oc2_latch_a: assert property (
		oc2_x && !vuv_s && (seq_q == SEQ_START || seq_q == SEQ_IGNITE) |=> seq_q == SEQ_FAULT)
		else $error("Second-level overcurrent did not latch shutdown.");
	cap2_fault_a: assert property (
		cap2_x && !vuv_s && run_mode |=> seq_q == SEQ_FAULT)
		else $error("Capacitive load two did not fault.");
	dead_gap_a: assert property (
		$fell(low_side_gate_out) |-> !high_side_gate_out [*8])
		else $error("High side rose inside the dead time.");
	boost_oc_off_a: assert property (
		boc_x && boost_run && bst_q == BST_ON |=> bst_q == BST_OFF ##1 !boost_gate_out)
		else $error("Boost overcurrent did not end the pulse.");
	ov_stop_a: assert property (
		bov_s |=> !boost_gate_out)
		else $error("Boost gate stayed on during overvoltage.");
	restart_timer_a: assert property (
		boost_run && bst_q == BST_OFF && bcnt_q >= RESTART_LIM |=> bst_q == BST_ON)
		else $error("Restart timer missed a boost cycle.");
endmodule : bps_top

// ### tb/bps_plant.sv
// Far side: half-bridge oscillator and boost choke with its zero-current winding.
module bps_plant #(
	parameter int unsigned OSC_HALF = 1000,
	parameter int unsigned ZCD_DLY = 150
) (
	input wire logic clk_in,
	input wire logic osc_en_in,
	input wire logic zcd_en_in,
	input wire logic boost_gate_in,
	output logic inv_osc_out,
	output logic zcd_high_out,
	output logic zcd_low_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic osc_q = 1'b0;
	int osc_cnt_q = 0;
	int zcd_cnt_q = ZCD_DLY;
	logic demag;
	// The oscillator stands still when disabled, so the inverter sees no flips.
	always @(posedge clk_in) begin
		if (!osc_en_in) begin
			osc_cnt_q <= 0;
		end else if (osc_cnt_q == OSC_HALF - 1) begin
			osc_cnt_q <= 0;
			osc_q <= ~osc_q;
		end else begin
			osc_cnt_q <= osc_cnt_q + 1;
		end
	end
	// The choke demagnetises for ZCD_DLY cycles after the gate opens; a weak winding never
	// crosses the upper level, which starves the design of zero-current falls.
	always @(posedge clk_in) begin
		if (boost_gate_in) begin
			zcd_cnt_q <= 0;
		end else if (zcd_cnt_q < ZCD_DLY) begin
			zcd_cnt_q <= zcd_cnt_q + 1;
		end
	end
	assign demag = zcd_en_in && !boost_gate_in && (zcd_cnt_q < ZCD_DLY);
	assign inv_osc_out = osc_q;
	assign zcd_high_out = demag;
	assign zcd_low_out = !demag;
endmodule : bps_plant

// ### tb/bps_top_bench.sv
// Directed bench for the ballast supervisor with shortened timers.
module bps_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import bps_pkg::*;
	localparam int TOFF = 200;
	localparam int RESTART = 300;
	localparam int RETRY = 300;
	localparam int PREH = 500;
	localparam int ZDLY = 150;
	localparam int LIM = 2000;
	localparam int TONMAX = 1100;
	localparam int OSCH = 1000;
	localparam int LS = 0;
	localparam int HS = 1;
	localparam int BG = 2;
	localparam int FH = 3;
	localparam int FLT = 4;
	localparam int IOV = 5;
	localparam int DCM = 6;
	localparam int RUN = 7;
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic inv_oc1 = 1'b0, inv_oc2 = 1'b0, inv_pos = 1'b0, inv_neg = 1'b0, boost_oc = 1'b0;
	logic vcc_on = 1'b0, vcc_uv = 1'b0, bus_uv = 1'b0, bus_ov = 1'b0, bus_rel = 1'b0;
	logic bus_ok = 1'b0, lamp_lit = 1'b0, osc_en = 1'b0, zcd_en = 1'b0;
	logic inv_slope = 1'b0, inv_oc3 = 1'b0, bus_open = 1'b0, line_low = 1'b0, light_load = 1'b0;
	logic inv_osc, zcd_high, zcd_low, ls, hs, bg, fh, flt, iov, dcm, run;
	wire logic [7:0] outs = {run, dcm, iov, flt, fh, bg, hs, ls};
	int err_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int n;

	bps_top #(.CAP2_LIM(LIM), .CAP1_LIM(LIM), .BUSOV_LIM(LIM), .RETRY_LIM(RETRY),
		.PREHEAT_LIM(PREH), .RESTART_LIM(RESTART), .BOOST_TOFF(TOFF),
		.BOOST_TONMAX(TONMAX)) i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.inv_oc1_in(inv_oc1), .inv_slope_in(inv_slope), .inv_oc2_in(inv_oc2),
		.inv_pos_in(inv_pos), .inv_neg_in(inv_neg), .inv_oc3_in(inv_oc3),
		.boost_oc_in(boost_oc), .zcd_high_in(zcd_high), .zcd_low_in(zcd_low),
		.vcc_on_in(vcc_on), .vcc_uv_in(vcc_uv), .bus_open_in(bus_open),
		.bus_uv_in(bus_uv), .bus_ov_in(bus_ov), .bus_rel_in(bus_rel), .bus_ok_in(bus_ok),
		.line_low_in(line_low), .light_load_in(light_load), .inv_osc_in(inv_osc),
		.lamp_lit_in(lamp_lit),
		.low_side_gate_out(ls), .high_side_gate_out(hs), .boost_gate_out(bg),
		.freq_hold_out(fh), .fault_out(flt), .inv_ov_out(iov), .dcm_out(dcm), .run_out(run));
	bps_plant #(.OSC_HALF(OSCH), .ZCD_DLY(ZDLY)) i_plant (.clk_in(clk_in), .osc_en_in(osc_en),
		.zcd_en_in(zcd_en), .boost_gate_in(bg), .inv_osc_out(inv_osc), .zcd_high_out(zcd_high),
		.zcd_low_out(zcd_low));

	always #2 clk_in = ~clk_in;

	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	// A hang is cut short well beyond the roughly 33000 cycles the tests need.
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			err_count++;
			final_report();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %0d seen %0d", what, exp, seen);
		end
	endtask : chk

	// Out of range is reported against the nearest bound, so a mismatch stays one line.
	task automatic rng(input string what, input int v, input int lo, input int hi);
		chk(what, v, (v < lo) ? lo : ((v > hi) ? hi : v));
	endtask : rng

	// Outputs are sampled on the falling edge, clear of the design's updates.
	task automatic waitv(input int idx, input logic val, input int lim);
		n = 0;
		while (outs[idx] !== val && n < lim) begin
			@(negedge clk_in);
			n++;
		end
	endtask : waitv

	// Gates may never overlap.
	always @(negedge clk_in) begin
		if (ls === 1'b1 && hs === 1'b1) begin
			chk("gate overlap", 32'h1, 32'h0);
		end
	end

	task automatic t_boost;
		int ton0;
		ton0 = BOOST_TON0_CYC;
		@(posedge clk_in);
		vcc_on <= 1'b1;
		zcd_en <= 1'b1;
		waitv(BG, 1'b1, 20);
		rng("boost start", n, 1, 8);
		waitv(BG, 1'b0, 2000);
		rng("first on time", n, ton0 - 1, ton0 + 1);
		waitv(BG, 1'b1, 2000);
		rng("fixed off time", n, TOFF - 1, TOFF + 1);
		waitv(BG, 1'b0, 2000);
		rng("second on time", n, ton0 + TON_STEP_CYC - 1, ton0 + TON_STEP_CYC + 1);
		repeat (10) begin
			waitv(BG, 1'b1, 2000);
			waitv(BG, 1'b0, 2000);
		end
		waitv(BG, 1'b1, 2000);
		rng("zero current off time", n, ZDLY, ZDLY + 8);
		@(posedge clk_in);
		light_load <= 1'b1;
		waitv(DCM, 1'b1, 20);
		rng("light load mode", n, 1, 6);
		waitv(BG, 1'b0, 2000);
		waitv(BG, 1'b1, 1000);
		rng("light load gap", n, RESTART - 1, RESTART + 4);
		@(posedge clk_in);
		light_load <= 1'b0;
		line_low <= 1'b1;
		waitv(BG, 1'b0, 2000);
		rng("low line on time", n, TONMAX * 5 / 4 - 4, TONMAX * 5 / 4 + 4);
		waitv(BG, 1'b1, 1000);
		@(posedge clk_in);
		line_low <= 1'b0;
		zcd_en <= 1'b0;
		waitv(BG, 1'b0, 2000);
		waitv(BG, 1'b1, 1000);
		rng("restart off time", n, RESTART - 1, RESTART + 4);
		@(posedge clk_in);
		zcd_en <= 1'b1;
		waitv(BG, 1'b0, 2000);
		waitv(BG, 1'b1, 2000);
		@(posedge clk_in);
		boost_oc <= 1'b1;
		waitv(BG, 1'b0, 200);
		rng("boost overcurrent cut", n, 50, 58);
		@(posedge clk_in);
		boost_oc <= 1'b0;
		$display("test boost done");
	endtask : t_boost

	task automatic t_run;
		chk("run before bus ok", run, 1'b0);
		@(posedge clk_in);
		bus_ok <= 1'b1;
		lamp_lit <= 1'b1;
		inv_pos <= 1'b1;
		osc_en <= 1'b1;
		waitv(RUN, 1'b1, 2000);
		rng("start with preheat", n, PREH, PREH + 20);
		waitv(LS, 1'b1, 3000);
		waitv(LS, 1'b0, 3000);
		waitv(HS, 1'b1, 1000);
		rng("slow dead time", n, 620, 634);
		@(posedge clk_in);
		inv_neg <= 1'b1;
		waitv(HS, 1'b0, 3000);
		waitv(LS, 1'b1, 1000);
		rng("fast dead time", n, 311, 322);
		@(posedge clk_in);
		inv_neg <= 1'b0;
		$display("test run done");
	endtask : t_run

	task automatic t_bus;
		waitv(BG, 1'b1, 2000);
		@(posedge clk_in);
		bus_open <= 1'b1;
		waitv(BG, 1'b0, 20);
		rng("open loop stop", n, 1, 5);
		@(posedge clk_in);
		bus_open <= 1'b0;
		waitv(BG, 1'b1, 2000);
		@(posedge clk_in);
		bus_ov <= 1'b1;
		bus_rel <= 1'b1;
		waitv(BG, 1'b0, 20);
		rng("overvoltage stop", n, 1, 5);
		waitv(BG, 1'b1, 400);
		chk("held in overvoltage", n, 400);
		@(posedge clk_in);
		bus_ov <= 1'b0;
		waitv(BG, 1'b1, 400);
		chk("held above release", n, 400);
		@(posedge clk_in);
		bus_rel <= 1'b0;
		waitv(BG, 1'b1, 600);
		rng("boost re-enabled", n, 1, RESTART + 10);
		@(posedge clk_in);
		bus_ov <= 1'b1;
		bus_rel <= 1'b1;
		waitv(IOV, 1'b1, LIM + 100);
		rng("inverter overvoltage", n, LIM, LIM + 12);
		chk("gates off in power down", {run, ls, hs}, 3'h0);
		@(posedge clk_in);
		bus_ov <= 1'b0;
		bus_rel <= 1'b0;
		waitv(RUN, 1'b1, 2000);
		chk("overvoltage restart", {run, iov}, 2'h2);
		@(posedge clk_in);
		bus_uv <= 1'b1;
		waitv(RUN, 1'b0, 20);
		rng("undervoltage power down", n, 1, 6);
		repeat (20) @(posedge clk_in);
		bus_uv <= 1'b0;
		lamp_lit <= 1'b0;
		inv_slope <= 1'b1;
		inv_oc1 <= 1'b1;
		waitv(FH, 1'b1, 2000);
		rng("retry skips preheat", n, RETRY - 30, RETRY + 30);
		@(posedge clk_in);
		inv_slope <= 1'b0;
		inv_oc1 <= 1'b0;
		repeat (20) @(negedge clk_in);
		chk("sweep hold kept", {run, fh}, 2'h1);
		@(posedge clk_in);
		lamp_lit <= 1'b1;
		waitv(RUN, 1'b1, 20);
		chk("hold ends in run", fh, 1'b0);
		$display("test bus done");
	endtask : t_bus

	task automatic t_fault;
		@(posedge clk_in);
		inv_oc1 <= 1'b1;
		repeat (100) @(posedge clk_in);
		inv_oc1 <= 1'b0;
		repeat (200) @(negedge clk_in);
		chk("short overcurrent ignored", flt, 1'b0);
		@(posedge clk_in);
		inv_oc1 <= 1'b1;
		waitv(FLT, 1'b1, 300);
		rng("run overcurrent", n, 126, 134);
		@(posedge clk_in);
		inv_oc1 <= 1'b0;
		lamp_lit <= 1'b0;
		repeat (5) @(negedge clk_in);
		chk("gates off in fault", outs[2:0], 3'h0);
		@(posedge clk_in);
		vcc_uv <= 1'b1;
		bus_ok <= 1'b0;
		waitv(FLT, 1'b0, 20);
		rng("lockout clears fault", n, 1, 6);
		repeat (5) @(negedge clk_in);
		chk("gates low in lockout", outs[2:0], 3'h0);
		@(posedge clk_in);
		vcc_uv <= 1'b0;
		repeat (20) @(posedge clk_in);
		inv_oc2 <= 1'b1;
		waitv(FLT, 1'b1, 300);
		rng("start overcurrent", n, 126, 134);
		@(posedge clk_in);
		inv_oc2 <= 1'b0;
		vcc_uv <= 1'b1;
		bus_ok <= 1'b1;
		lamp_lit <= 1'b1;
		inv_oc3 <= 1'b1;
		repeat (5) @(posedge clk_in);
		vcc_uv <= 1'b0;
		waitv(RUN, 1'b1, 2000);
		rng("reached run again", n, PREH, PREH + 40);
		waitv(FLT, 1'b1, 3 * LIM);
		rng("capacitive load fault", n, LIM, 2 * LIM);
		@(posedge clk_in);
		inv_oc3 <= 1'b0;
		$display("test fault done");
	endtask : t_fault

	initial begin
		repeat (3) @(posedge clk_in);
		chk("outputs in reset", outs, 8'h00);
		arst_n_in <= 1'b1;
		repeat (50) @(negedge clk_in);
		chk("outputs in lockout", outs, 8'h00);
		t_boost();
		t_run();
		t_bus();
		t_fault();
		final_report();
	end
endmodule : bps_top_bench
